// ==== inc/rst_ctl_pkg.sv ====
/*
 * package for the reset source controller: register map, field positions,
 * protect codes, timing figures and carrier structs.
 * assumes a 200 MHz clock and a simple strobe register port.
 */
`default_nettype none
package rst_ctl_pkg;
	// =====================================================================
	// register map
	localparam logic [3:0] ADDR_CAUSE = 4'h0;
	localparam logic [3:0] ADDR_SYSCFG3 = 4'h1;
	localparam logic [3:0] ADDR_PROTECT = 4'h2;
	localparam logic [3:0] ADDR_STATUS = 4'h3;
	// =====================================================================
	// field positions of the cause and SYSCFG3 registers, cause reset value and protect codes
	localparam int CAUSE_VOLT = 0;
	localparam int CAUSE_WDT = 1;
	localparam int CAUSE_CLK = 2;
	localparam int CAUSE_TRIM = 3;
	localparam int CAUSE_FLASH = 4;
	localparam int TRIM_FAULT = 5;
	localparam int CLEAR_REQ = 7;
	localparam int CFG3_EXT_RESET_DISABLE_BIT = 0;
	localparam logic [7:0] CAUSE_RESET = 8'h00;
	localparam logic [7:0] PROT_CODE_CLEAR = 8'h71;
	localparam logic [7:0] PROT_CODE_PINFN = 8'hB2;
	// =====================================================================
	// timing
	localparam int CLK_MHZ = 200;
	localparam int PIN_LOW_NS = 5000;
	localparam int PIN_LOW_CYC = (PIN_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int WARMUP_CYC = 4096;
	localparam int SYNC_STAGES = 2;
	// =====================================================================
	// carriers
	typedef struct packed {
		logic volt;
		logic wdt;
		logic clk;
		logic flash;
	} int_src_s;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} reg_req_s;
endpackage : rst_ctl_pkg
`default_nettype wire

// ==== rtl/reset_source_control.sv ====
/*
 * reset source controller: pin reset filter, internal reset factors,
 * warm-up sequencing with trim load, cause register and protected writes.
 * assumes power-on reset arrives on i_rst_b and all inputs are synchronous.
 */
`timescale 1ns/10ps
`default_nettype none
// Contract
// R01: pin must stay low at least 5 us before reset is taken.
// R02: pin rising edge starts warm-up; core released after it ends.
// R03: voltage detect event raises an internal reset.
// R04: watchdog overflow raises an internal reset.
// R05: deadlocking oscillator setting raises an internal reset.
// R06: trim bits are loaded and latched during warm-up.
// R07: abnormal loaded trim bits set the trim fault flag.
// R08: latched trim bits corrupted in operation raise an internal reset.
// R09: flash access while in standby raises an internal reset.
// R10: cause register shows which internal factor caused the reset.
// R11: among resets, cause register cleared only by pin or power-on reset.
// R12: clear request then code 0x71 clears the whole cause register.
// R13: clear request bit returns to zero after the clear.
// R14: software issues request and code back to back in normal mode.
// R15: disable bit one then code 0xB2 makes the pin a port.
// R16: disable bit zero then code 0xB2 restores pin reset.
// R17: board keeps pin high through power-up and warm-up when a port.
// R18: software sets pin as pulled-up input before reassignment.
// R19: pin function switched only while the pin is high.
// R20: 0xB2 commit done in single clock normal mode.
// R21: power-on and pin reset are combined by OR.
// R22: one system reset covers all enabled sources, then warm-up.
module reset_source_control #(
	parameter int WARMUP_CYCLES = rst_ctl_pkg::WARMUP_CYC,
	parameter int TRIM_W = 8
) (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	input wire logic i_reset_pin_b,
	input wire rst_ctl_pkg::int_src_s i_src,
	input wire logic [TRIM_W-1:0] i_trim_nvm,
	input wire logic i_trim_nvm_ok,
	input wire logic [TRIM_W-1:0] i_trim_check,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	output logic o_sys_rst_b,
	output logic o_warmup,
	output logic [TRIM_W-1:0] o_trim,
	output logic o_pin_is_port
);
	initial
	begin
		if (WARMUP_CYCLES < 2 || TRIM_W < 1)
			$error("reset_source_control: bad parameter");
	end

	// =====================================================================
	// pin filter and reset request
	localparam int LOWW = $clog2(rst_ctl_pkg::PIN_LOW_CYC + 1);
	localparam int WUW = $clog2(WARMUP_CYCLES + 1);
	localparam logic [LOWW-1:0] LOW_MAX = LOWW'(rst_ctl_pkg::PIN_LOW_CYC);
	localparam logic [WUW-1:0] WU_MAX = WUW'(WARMUP_CYCLES);

	typedef enum logic [1:0] {ST_RESET, ST_WARMUP, ST_RUN} seq_e;

	logic [LOWW-1:0] low_cnt_q, low_cnt_d;
	logic pin_rst_q, pin_rst_d;
	logic [WUW-1:0] wu_cnt_q, wu_cnt_d;
	seq_e st_q, st_d;
	logic [7:0] cause_q, cause_d;
	logic ext_reset_disable_q, ext_reset_disable_d;
	logic ext_reset_disable_shadow_q, ext_reset_disable_shadow_d;
	logic [TRIM_W-1:0] trim_q, trim_d;
	logic [7:0] rdata_q, rdata_d;
	logic int_rst_q, int_rst_d;
	logic [4:0] int_cause;
	logic int_any;
	logic trim_bad;

	function automatic logic is_wr(input logic wr, input logic [3:0] a, input logic [3:0] t);
		is_wr = wr && (a == t);
	endfunction : is_wr

	// the filter counts only while the pin is low; a short glitch is ignored
	always_comb
	begin
		low_cnt_d = low_cnt_q;
		pin_rst_d = pin_rst_q;
		if (ext_reset_disable_q || i_reset_pin_b)
		begin
			low_cnt_d = '0;
			pin_rst_d = 1'b0;
		end
		else if (low_cnt_q != LOW_MAX)
			low_cnt_d = low_cnt_q + 1'b1;
		else
			pin_rst_d = 1'b1; // R01
	end

	// =====================================================================
	// internal factors
	assign trim_bad = (st_q == ST_RUN) && (trim_q != i_trim_check);
	always_comb
	begin
		int_cause = '0;
		int_cause[rst_ctl_pkg::CAUSE_VOLT] = i_src.volt; // R03
		int_cause[rst_ctl_pkg::CAUSE_WDT] = i_src.wdt; // R04
		int_cause[rst_ctl_pkg::CAUSE_CLK] = i_src.clk; // R05
		int_cause[rst_ctl_pkg::CAUSE_TRIM] = trim_bad; // R08
		int_cause[rst_ctl_pkg::CAUSE_FLASH] = i_src.flash; // R09
	end
	assign int_any = |int_cause;

	// =====================================================================
	// sequencer: reset, warm-up with trim load, run
	always_comb
	begin
		st_d = st_q;
		wu_cnt_d = wu_cnt_q;
		trim_d = trim_q;
		int_rst_d = 1'b0;
		case (st_q)
			ST_RESET:
			begin
				wu_cnt_d = '0;
				if (!pin_rst_q && !int_rst_q) // R22
					st_d = ST_WARMUP; // R02
			end
			ST_WARMUP:
			begin
				if (wu_cnt_q == '0)
					trim_d = i_trim_nvm; // R06
				wu_cnt_d = wu_cnt_q + 1'b1;
				if (wu_cnt_q == WU_MAX - 1'b1)
					st_d = ST_RUN;
			end
			ST_RUN: ;
			default: st_d = ST_RESET;
		endcase
		if (pin_rst_q) // R21
			st_d = ST_RESET;
		if (int_any && st_q == ST_RUN)
		begin
			int_rst_d = 1'b1;
			st_d = ST_RESET;
		end
	end

	// =====================================================================
	// registers: cause, protected settings, read port
	always_comb
	begin
		cause_d = cause_q;
		ext_reset_disable_d = ext_reset_disable_q;
		ext_reset_disable_shadow_d = ext_reset_disable_shadow_q;
		rdata_d = '0;
		if (pin_rst_q)
			cause_d = rst_ctl_pkg::CAUSE_RESET; // R11
		else
		begin
			if (is_wr(i_wr, i_addr, rst_ctl_pkg::ADDR_CAUSE))
				cause_d[rst_ctl_pkg::CLEAR_REQ] = i_wdata[rst_ctl_pkg::CLEAR_REQ];
			if (is_wr(i_wr, i_addr, rst_ctl_pkg::ADDR_PROTECT)
				&& i_wdata == rst_ctl_pkg::PROT_CODE_CLEAR
				&& cause_q[rst_ctl_pkg::CLEAR_REQ])
				cause_d = '0; // R12 R13
			// new factor wins over a simultaneous clear
			if (int_any && st_q == ST_RUN)
				cause_d[4:0] = cause_d[4:0] | int_cause; // R10
			if (st_q == ST_WARMUP && wu_cnt_q == '0 && !i_trim_nvm_ok)
				cause_d[rst_ctl_pkg::TRIM_FAULT] = 1'b1; // R07
		end
		if (is_wr(i_wr, i_addr, rst_ctl_pkg::ADDR_SYSCFG3))
			ext_reset_disable_shadow_d = i_wdata[rst_ctl_pkg::CFG3_EXT_RESET_DISABLE_BIT];
		if (is_wr(i_wr, i_addr, rst_ctl_pkg::ADDR_PROTECT)
			&& i_wdata == rst_ctl_pkg::PROT_CODE_PINFN)
			ext_reset_disable_d = ext_reset_disable_shadow_q; // R15 R16
		if (i_rd)
		begin
			case (i_addr)
				rst_ctl_pkg::ADDR_CAUSE: rdata_d = cause_q;
				rst_ctl_pkg::ADDR_SYSCFG3: rdata_d = {7'h00, ext_reset_disable_shadow_q};
				rst_ctl_pkg::ADDR_STATUS: rdata_d = {5'h00, ext_reset_disable_q, st_q};
				default: rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			low_cnt_q <= '0;
			pin_rst_q <= 1'b0;
			wu_cnt_q <= '0;
			st_q <= ST_RESET;
			cause_q <= rst_ctl_pkg::CAUSE_RESET;
			ext_reset_disable_q <= 1'b0;
			ext_reset_disable_shadow_q <= 1'b0;
			trim_q <= '0;
			rdata_q <= '0;
			int_rst_q <= 1'b0;
		end
		else if (i_ce)
		begin
			low_cnt_q <= low_cnt_d;
			pin_rst_q <= pin_rst_d;
			wu_cnt_q <= wu_cnt_d;
			st_q <= st_d;
			cause_q <= cause_d;
			ext_reset_disable_q <= ext_reset_disable_d;
			ext_reset_disable_shadow_q <= ext_reset_disable_shadow_d;
			trim_q <= trim_d;
			rdata_q <= rdata_d;
			int_rst_q <= int_rst_d;
		end
	end

	assign o_rdata = rdata_q;
	assign o_sys_rst_b = (st_q == ST_RUN);
	assign o_warmup = (st_q == ST_WARMUP);
	assign o_trim = trim_q;
	assign o_pin_is_port = ext_reset_disable_q;

	// =====================================================================
	// checks
	pin_filter_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R01
		$rose(pin_rst_q) |-> $past(low_cnt_q) == LOW_MAX)
		else $error("pin reset taken before filter time");
	warmup_entry_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R02
		$rose(o_sys_rst_b) |-> $past(st_q) == ST_WARMUP)
		else $error("run entered without warm-up");
	int_reset_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R22
		i_ce && o_sys_rst_b && int_any |=> !o_sys_rst_b)
		else $error("internal factor did not reset");
	cause_record_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R10
		i_ce && o_sys_rst_b && i_src.wdt && !pin_rst_q |=> cause_q[rst_ctl_pkg::CAUSE_WDT])
		else $error("watchdog cause not recorded");
	pin_clear_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R11
		i_ce && pin_rst_q |=> cause_q == rst_ctl_pkg::CAUSE_RESET)
		else $error("cause not cleared by pin reset");
	clear_seq_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R12
		i_ce && !pin_rst_q && !(int_any && o_sys_rst_b) && !o_warmup
		&& is_wr(i_wr, i_addr, rst_ctl_pkg::ADDR_PROTECT)
		&& i_wdata == rst_ctl_pkg::PROT_CODE_CLEAR && cause_q[rst_ctl_pkg::CLEAR_REQ]
		|=> cause_q == 8'h00)
		else $error("cause clear sequence failed");
	pin_port_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R15
		i_ce && is_wr(i_wr, i_addr, rst_ctl_pkg::ADDR_PROTECT)
		&& i_wdata == rst_ctl_pkg::PROT_CODE_PINFN |=> o_pin_is_port == $past(ext_reset_disable_shadow_q))
		else $error("pin function commit wrong");
	port_no_reset_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R15
		ext_reset_disable_q |-> !pin_rst_q)
		else $error("port pin caused reset");

	// =====================================================================
	// sequencing and trim checks
	// the first warm-up cycle is the only load point, so a late check would miss it
	trim_latch_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R06
		i_ce && o_warmup && wu_cnt_q == '0 |=> o_trim == $past(i_trim_nvm))
		else $error("trim not latched in warm-up");
	trim_fault_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R07
		i_ce && !pin_rst_q && o_warmup && wu_cnt_q == '0 && !i_trim_nvm_ok
		|=> cause_q[rst_ctl_pkg::TRIM_FAULT])
		else $error("trim fault flag not set");
	trim_reset_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R08
		i_ce && o_sys_rst_b && o_trim != i_trim_check |=> !o_sys_rst_b)
		else $error("corrupted trim did not reset");
	release_warmup_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R02
		i_ce && st_q == ST_RESET && !pin_rst_q && !int_rst_q |=> o_warmup)
		else $error("warm-up not started on release");
	warmup_end_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R02
		i_ce && o_warmup && wu_cnt_q == WU_MAX - 1'b1 && !pin_rst_q |=> o_sys_rst_b)
		else $error("run not entered after warm-up");
	pin_reset_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R21
		i_ce && pin_rst_q |=> !o_sys_rst_b && !o_warmup)
		else $error("pin reset did not hold system");
	ce_freeze_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R22
		!i_ce |=> $stable(st_q) && $stable(cause_q))
		else $error("state moved with clock enable low");

	// =====================================================================
	// cause recording and protected write checks
	volt_cause_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R03
		i_ce && o_sys_rst_b && i_src.volt && !pin_rst_q
		|=> cause_q[rst_ctl_pkg::CAUSE_VOLT] && !o_sys_rst_b)
		else $error("voltage cause not recorded");
	clk_cause_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R05
		i_ce && o_sys_rst_b && i_src.clk && !pin_rst_q
		|=> cause_q[rst_ctl_pkg::CAUSE_CLK] && !o_sys_rst_b)
		else $error("clock cause not recorded");
	flash_cause_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R09
		i_ce && o_sys_rst_b && i_src.flash && !pin_rst_q
		|=> cause_q[rst_ctl_pkg::CAUSE_FLASH] && !o_sys_rst_b)
		else $error("flash cause not recorded");
	clear_req_drop_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R13
		i_ce && !pin_rst_q && cause_q[rst_ctl_pkg::CLEAR_REQ]
		&& is_wr(i_wr, i_addr, rst_ctl_pkg::ADDR_PROTECT)
		&& i_wdata == rst_ctl_pkg::PROT_CODE_CLEAR |=> !cause_q[rst_ctl_pkg::CLEAR_REQ])
		else $error("clear request did not drop");
	pin_restore_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // R16
		i_ce && !ext_reset_disable_shadow_q && is_wr(i_wr, i_addr, rst_ctl_pkg::ADDR_PROTECT)
		&& i_wdata == rst_ctl_pkg::PROT_CODE_PINFN |=> !o_pin_is_port)
		else $error("pin reset not restored");
endmodule : reset_source_control
`default_nettype wire

// ==== testbench/reset_sources_model.sv ====
/*
 * far side of the reset controller: the reset pin and the internal monitors.
 * assumes one command pulse at a time from the bench.
 */
`timescale 1ns/10ps
`default_nettype none
module reset_sources_model (
	input wire logic i_mclk,
	input wire logic i_fire,
	input wire logic [2:0] i_kind,
	input wire logic [15:0] i_len,
	output logic o_pin_b,
	output rst_ctl_pkg::int_src_s o_src
);
	// =========================================================
	// pin low pulse and one-cycle monitor events
	logic [15:0] low_q = 16'h0;
	logic [3:0] src_q = 4'h0;
	// pin has a pull-up, so it rests high outside a pulse
	assign o_pin_b = (low_q == 16'h0);
	assign o_src = rst_ctl_pkg::int_src_s'(src_q);
	always @(posedge i_mclk)
	begin
		if (i_fire && i_kind == 3'h0)
			low_q <= i_len;
		else if (low_q != 16'h0)
			low_q <= low_q - 16'h1;
		src_q <= (i_fire && i_kind != 3'h0) ? 4'h8 >> (i_kind - 3'h1) : 4'h0;
	end
endmodule : reset_sources_model
`default_nettype wire

// ==== testbench/reset_source_control_tb.sv ====
/*
 * self-checking bench for the reset source controller.
 * assumes the package and the partner model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin failures++; \
	$display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module reset_source_control_tb;
	localparam int WU = 16;
	localparam int CB [4] = '{rst_ctl_pkg::CAUSE_VOLT, rst_ctl_pkg::CAUSE_WDT,
		rst_ctl_pkg::CAUSE_CLK, rst_ctl_pkg::CAUSE_FLASH};
	logic i_mclk = 1'b0;
	logic i_rst_b = 1'b0;
	logic fire = 1'b0;
	logic [2:0] kind = 3'h0;
	logic [15:0] len = 16'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [3:0] i_addr = 4'h0;
	logic [7:0] i_wdata = 8'h00;
	logic [7:0] trim_nvm;
	logic [7:0] trim_check;
	logic trim_ok = 1'b1;
	logic ce = 1'b1;
	logic [31:0] seed = 32'h983DBD69;
	logic pin_b;
	rst_ctl_pkg::int_src_s src;
	logic [7:0] o_rdata;
	logic o_sys_rst_b;
	logic o_warmup;
	logic [7:0] o_trim;
	logic o_pin_is_port;
	int failures = 0;
	int total_checks = 0;
	initial
	begin
		forever #2.5 i_mclk = ~i_mclk;
	end
	reset_sources_model u_src (.i_mclk(i_mclk), .i_fire(fire), .i_kind(kind), .i_len(len),
		.o_pin_b(pin_b), .o_src(src));
	reset_source_control #(.WARMUP_CYCLES(WU), .TRIM_W(8)) u_dut (.i_mclk(i_mclk),
		.i_rst_b(i_rst_b), .i_ce(ce), .i_reset_pin_b(pin_b), .i_src(src),
		.i_trim_nvm(trim_nvm), .i_trim_nvm_ok(trim_ok), .i_trim_check(trim_check),
		.i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
		.o_sys_rst_b(o_sys_rst_b), .o_warmup(o_warmup), .o_trim(o_trim),
		.o_pin_is_port(o_pin_is_port));
	// =========================================================
	// helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic tally_and_finish();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge i_mclk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1;
		d = o_rdata;
	endtask : rd
	task automatic go(input logic [2:0] k, input logic [15:0] n);
		@(posedge i_mclk);
		fire <= 1'b1;
		kind <= k;
		len <= n;
		@(posedge i_mclk);
		fire <= 1'b0;
	endtask : go
	// counts warm-up cycles; the reset may begin late, so run needs a warm-up seen first
	task automatic wait_run(output int n);
		n = 0;
		for (int i = 0; i < 5000 && !(o_sys_rst_b === 1'b1 && n > 0); i++)
		begin
			@(posedge i_mclk);
			#1;
			if (o_warmup === 1'b1)
				n++;
		end
		if (o_sys_rst_b !== 1'b1)
		begin
			failures++;
			tally_and_finish();
		end
	endtask : wait_run
	// =========================================================
	// scenarios
	initial
	begin
		int n;
		logic [7:0] r;
		logic [7:0] acc;
		logic [7:0] v;
		seed = lfsr(seed);
		trim_nvm = seed[7:0];
		trim_check = seed[7:0];
		repeat (5) @(posedge i_mclk);
		i_rst_b <= 1'b1;
		wait_run(n);
		`CHK("warmup_por", WU, n)
		`CHK("trim_load", trim_nvm, o_trim)
		rd(rst_ctl_pkg::ADDR_CAUSE, r);
		`CHK("cause_por", 8'h00, r)
		acc = 8'h00;
		for (int k = 1; k <= 4; k++)
		begin
			go(3'(k), 16'h0);
			wait_run(n);
			acc[CB[k-1]] = 1'b1;
			rd(rst_ctl_pkg::ADDR_CAUSE, r);
			`CHK("cause_int", acc, r)
		end
		wr(rst_ctl_pkg::ADDR_PROTECT, 8'h71);
		rd(rst_ctl_pkg::ADDR_CAUSE, r);
		`CHK("clear_refused", acc, r)
		wr(rst_ctl_pkg::ADDR_CAUSE, 8'h80);
		wr(rst_ctl_pkg::ADDR_PROTECT, 8'h71);
		rd(rst_ctl_pkg::ADDR_CAUSE, r);
		`CHK("cause_clear", 8'h00, r)
		$display("test internal factors done");
		seed = lfsr(seed);
		v = trim_nvm ^ (seed[7:0] | 8'h01);
		@(posedge i_mclk);
		trim_nvm <= v;
		trim_check <= v;
		trim_ok <= 1'b0;
		wait_run(n);
		trim_ok <= 1'b1;
		`CHK("trim_reload", v, o_trim)
		rd(rst_ctl_pkg::ADDR_CAUSE, r);
		`CHK("cause_trim", 8'h28, r)
		$display("test trim done");
		go(3'h0, 16'd900);
		repeat (950) @(posedge i_mclk);
		`CHK("short_pulse", 1'b1, o_sys_rst_b)
		go(3'h0, 16'd1010);
		wait_run(n);
		`CHK("warmup_pin", WU, n)
		rd(rst_ctl_pkg::ADDR_CAUSE, r);
		`CHK("cause_pin", 8'h00, r)
		$display("test pin reset done");
		seed = lfsr(seed);
		wr(rst_ctl_pkg::ADDR_SYSCFG3, 8'h01);
		wr(rst_ctl_pkg::ADDR_PROTECT, seed[7:0] & 8'hFD);
		rd(rst_ctl_pkg::ADDR_STATUS, r);
		`CHK("bad_code", 8'h02, r)
		wr(rst_ctl_pkg::ADDR_PROTECT, 8'hB2);
		rd(rst_ctl_pkg::ADDR_STATUS, r);
		`CHK("port_on", 8'h06, r)
		go(3'h0, 16'd1010);
		repeat (1030) @(posedge i_mclk);
		`CHK("port_no_rst", 1'b1, o_sys_rst_b)
		wr(rst_ctl_pkg::ADDR_SYSCFG3, 8'h00);
		wr(rst_ctl_pkg::ADDR_PROTECT, 8'hB2);
		rd(rst_ctl_pkg::ADDR_STATUS, r);
		`CHK("port_off", 8'h02, r)
		`CHK("port_flag", 1'b0, o_pin_is_port)
		rd(rst_ctl_pkg::ADDR_PROTECT, r);
		`CHK("prot_read", 8'h00, r)
		rd(4'hF, r);
		`CHK("unmapped", 8'h00, r)
		$display("test pin function done");
		ce <= 1'b0;
		go(3'h2, 16'h0);
		repeat (4) @(posedge i_mclk);
		`CHK("ce_freeze", 1'b1, o_sys_rst_b)
		ce <= 1'b1;
		@(posedge i_mclk);
		rd(rst_ctl_pkg::ADDR_CAUSE, r);
		`CHK("cause_frozen", 8'h00, r)
		$display("test clock enable done");
		tally_and_finish();
	end
endmodule : reset_source_control_tb
`undef CHK
`default_nettype wire
